// >>> shared/hod_defs.vh
// Notes on behaviour
// - In drive-controlled homing only bits 0,1,2,3,5,6,7 and 8 of the option word take effect; the code also decodes bits 9 and 10 there.
// - In control-unit-controlled homing only bits 1,2,3 and 4 of the option word take effect.
// - Bit 0 picks travel direction, 0 toward increasing and 1 toward decreasing position.
// - Bit 1 picks the marker pulse after the home switch rising edge (0) or falling edge (1).
// - Bit 2 tells whether the home switch is wired to the control unit (0) or the drive (1).
// - With bit 5 set the home switch input is evaluated during homing.
// - Bit 6 at 0 evaluates the feedback marker pulse, at 1 ignores it.
// - Bit 7 at 0 stops anywhere, at 1 moves on to the reference position.
// - Bit 8 at 1 applies the homing distance in drive-controlled homing, at 0 it does not.
// - Bit 9 selects limit-switch homing and is valid only with bit 5 set and bit 10 clear.
// - Bit 10 selects positive-stop homing, valid only with bit 5 set and bit 9 clear, using clamp torque.
// - Drive-controlled homing clears feedback-valid at start and sets it only after a referenced stop.
`ifndef HOD_DEFS_VH
`define HOD_DEFS_VH
`define HOD_ADDR_OPT     2'h0
`define HOD_ADDR_CTRL    2'h1
`define HOD_ADDR_STAT    2'h2
`define HOD_OPT_RST      16'h0000
`define HOD_OPT_WMASK    16'h07ff
`define HOD_DRV_MASK     16'h01ef
`define HOD_CU_MASK      16'h001e
`define HOD_B_DIR        0
`define HOD_B_EDGE       1
`define HOD_B_SWDRV      2
`define HOD_B_EXTFB      3
`define HOD_B_ENONLY     4
`define HOD_B_SWEVAL     5
`define HOD_B_NOMARK     6
`define HOD_B_TOREF      7
`define HOD_B_DIST       8
`define HOD_B_LIMIT      9
`define HOD_B_PSTOP      10
`define HOD_C_DRV        0
`define HOD_C_CU         1
`define HOD_C_ABORT      2
`define HOD_S_BUSY       0
`define HOD_S_FBVALID    1
`define HOD_S_CONFERR    2
`define HOD_S_MODE_LO    3
`endif

// >>> core/hod_combo_chk.v
`default_nettype none
`include "hod_defs.vh"
module hod_combo_chk (
  // Option word
  input  wire [15:0] opt_word,
  // Verdict
  output wire        combo_bad
);
  wire lim_bad = opt_word[`HOD_B_LIMIT] &
                 (~opt_word[`HOD_B_SWEVAL] | opt_word[`HOD_B_PSTOP]);
  wire ps_bad  = opt_word[`HOD_B_PSTOP] &
                 (~opt_word[`HOD_B_SWEVAL] | opt_word[`HOD_B_LIMIT]);
  assign combo_bad = lim_bad | ps_bad;
endmodule
`default_nettype wire

// >>> core/hod_top.v
// The address map and the Avalon-MM interface to the registers were left to the implementer.
`default_nettype none
`include "hod_defs.vh"
module hod_top (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        sys_rst,
  // Avalon-MM slave
  input  wire [1:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  // Homing progress from motion logic
  input  wire        stopped_referenced,
  // Decoded options
  output reg         dir_negative,
  output reg         marker_after_fall,
  output reg         switch_at_drive,
  output reg         use_ext_feedback,
  output reg         enable_only,
  output reg         eval_home_switch,
  output reg         eval_marker,
  output reg         go_to_ref_pos,
  output reg         apply_home_dist,
  output reg         limit_switch_homing,
  output reg         positive_stop_homing,
  output reg         use_clamp_torque,
  // Status
  output reg         homing_active,
  output reg         fb_valid
);
  localparam ST_IDLE = 2'h0;
  localparam ST_DRV  = 2'h1;
  localparam ST_CU   = 2'h2;

  reg  [15:0] opt_q;
  reg  [1:0]  st_q;
  reg         rd_done_q;
  reg         wr_done_q;
  reg         ref_s1_q;
  reg         ref_s2_q;
  wire        combo_bad;
  wire [15:0] eff;

  // One wait cycle; turnaround keeps read data registered
  assign avs_waitrequest = (avs_read & ~rd_done_q) | (avs_write & ~wr_done_q);
  wire wr_fire = avs_write & ~wr_done_q;
  wire rd_fire = avs_read & ~rd_done_q;

  // Stop flag comes from another domain
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      ref_s1_q <= 1'b0;
      ref_s2_q <= 1'b0;
    end else begin
      ref_s1_q <= stopped_referenced;
      ref_s2_q <= ref_s1_q;
    end
  end

  hod_combo_chk u_chk (
    .opt_word  (opt_q),
    .combo_bad (combo_bad)
  );

  function [15:0] be_merge;
    input [15:0] old;
    input [15:0] nw;
    input [1:0]  be;
    begin
      be_merge = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
    end
  endfunction

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      opt_q     <= `HOD_OPT_RST;
      st_q      <= ST_IDLE;
      fb_valid  <= 1'b0;
      rd_done_q <= 1'b0;
      wr_done_q <= 1'b0;
      avs_readdata <= 32'h0;
    end else begin
      rd_done_q <= rd_fire;
      wr_done_q <= wr_fire;
      if (wr_fire && avs_address == `HOD_ADDR_OPT && st_q == ST_IDLE)
        opt_q <= be_merge(opt_q, avs_writedata[15:0], avs_byteenable[1:0]) & `HOD_OPT_WMASK;
      case (st_q)
        ST_IDLE: begin
          if (wr_fire && avs_address == `HOD_ADDR_CTRL && avs_byteenable[0]) begin
            if (avs_writedata[`HOD_C_DRV] && !combo_bad) begin
              st_q <= ST_DRV;
              fb_valid <= 1'b0;
            end else if (avs_writedata[`HOD_C_CU]) begin
              st_q <= ST_CU;
            end
          end
        end
        ST_DRV: begin
          if (ref_s2_q) begin
            fb_valid <= 1'b1;
            st_q <= ST_IDLE;
          end else if (wr_fire && avs_address == `HOD_ADDR_CTRL &&
                       avs_writedata[`HOD_C_ABORT]) begin
            st_q <= ST_IDLE;
          end
        end
        ST_CU: begin
          if (wr_fire && avs_address == `HOD_ADDR_CTRL && avs_writedata[`HOD_C_ABORT])
            st_q <= ST_IDLE;
        end
        default: st_q <= ST_IDLE;
      endcase
      if (rd_fire) begin
        case (avs_address)
          `HOD_ADDR_OPT:  avs_readdata <= {16'h0, opt_q};
          `HOD_ADDR_STAT: avs_readdata <= {27'h0, st_q, combo_bad, fb_valid,
                                           st_q != ST_IDLE};
          default:        avs_readdata <= 32'h0;
        endcase
      end
    end
  end

  // Effective word per homing kind
  // Drive mask, unit mask, or zero while idle
  assign eff = (st_q == ST_DRV) ? (opt_q & `HOD_DRV_MASK) :
               (st_q == ST_CU)  ? (opt_q & `HOD_CU_MASK)  : 16'h0;

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      dir_negative <= 1'b0;
      marker_after_fall <= 1'b0;
      switch_at_drive <= 1'b0;
      use_ext_feedback <= 1'b0;
      enable_only <= 1'b0;
      eval_home_switch <= 1'b0;
      eval_marker <= 1'b0;
      go_to_ref_pos <= 1'b0;
      apply_home_dist <= 1'b0;
      limit_switch_homing <= 1'b0;
      positive_stop_homing <= 1'b0;
      use_clamp_torque <= 1'b0;
      homing_active <= 1'b0;
    end else begin
      homing_active <= st_q != ST_IDLE;
      dir_negative <= eff[`HOD_B_DIR];
      marker_after_fall <= eff[`HOD_B_EDGE];
      switch_at_drive <= eff[`HOD_B_SWDRV];
      use_ext_feedback <= eff[`HOD_B_EXTFB];
      enable_only <= eff[`HOD_B_ENONLY];
      eval_home_switch <= eff[`HOD_B_SWEVAL];
      eval_marker <= (st_q != ST_IDLE) & ~eff[`HOD_B_NOMARK];
      go_to_ref_pos <= eff[`HOD_B_TOREF];
      apply_home_dist <= eff[`HOD_B_DIST];
      // Limit switch and positive stop modes, drive homing only
      limit_switch_homing <= (st_q == ST_DRV) & opt_q[`HOD_B_LIMIT] & ~combo_bad;
      positive_stop_homing <= (st_q == ST_DRV) & opt_q[`HOD_B_PSTOP] & ~combo_bad;
      use_clamp_torque <= (st_q == ST_DRV) & opt_q[`HOD_B_PSTOP] & ~combo_bad;
    end
  end
endmodule
`default_nettype wire

// >>> bench/hod_monitor.sv
`default_nettype none
module hod_monitor (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // Decoded
  input wire logic dir_negative,
  input wire logic apply_home_dist,
  input wire logic enable_only,
  input wire logic eval_home_switch,
  input wire logic eval_marker,
  input wire logic limit_switch_homing,
  input wire logic positive_stop_homing,
  input wire logic use_clamp_torque,
  input wire logic homing_active,
  input wire logic fb_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_clamp_pair: assert property (positive_stop_homing == use_clamp_torque)
    else $error("clamp torque differs from positive stop");
  a_combo_excl: assert property (!(limit_switch_homing && positive_stop_homing))
    else $error("limit and positive stop together");
  a_limit_needs_sw: assert property (limit_switch_homing |-> eval_home_switch)
    else $error("limit homing without switch");
  a_pstop_needs_sw: assert property (positive_stop_homing |-> eval_home_switch)
    else $error("positive stop without switch");
  a_cu_mask: assert property (enable_only |-> !dir_negative && !apply_home_dist)
    else $error("drive bits seen in unit homing");
  a_idle_zero: assert property (!homing_active |-> !eval_marker && !eval_home_switch)
    else $error("decoded output set while idle");
  // Unit homing leaves the flag alone, so only a clear is tied to a start
  a_fb_start: assert property ($fell(fb_valid) |=> $rose(homing_active))
    else $error("feedback valid cleared outside a homing start");
  a_fb_set_end: assert property ($rose(fb_valid) |-> homing_active)
    else $error("feedback valid set outside drive homing");
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("second wait state");
endmodule
bind hod_top hod_monitor u_hod_monitor (.*);
`default_nettype wire

// >>> bench/hod_motion_model.sv
`default_nettype none
module hod_motion_model #(parameter int DLY = 20) (
  // Clock and homing state
  input  wire logic clk_sys,
  input  wire logic homing_active,
  // Referenced stop
  output var  logic stopped_referenced = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  always @(posedge clk_sys) begin
    cnt <= homing_active ? cnt + 1 : 0;
    stopped_referenced <= homing_active && cnt >= DLY;
  end
endmodule
`default_nettype wire

// >>> bench/homing_option_decoder_tb.sv
`default_nettype none
module homing_option_decoder_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic [1:0]  avs_address = 2'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'h3;
  logic [31:0] avs_readdata, got;
  logic        avs_waitrequest, stopped_referenced, dir_negative, marker_after_fall;
  logic        switch_at_drive, use_ext_feedback, enable_only, eval_home_switch;
  logic        eval_marker, go_to_ref_pos, apply_home_dist, limit_switch_homing;
  logic        positive_stop_homing, use_clamp_torque, homing_active, fb_valid;
  int          num_errors = 0;
  int          check_count = 0;
  wire  [10:0] opts = {positive_stop_homing, limit_switch_homing, apply_home_dist,
    go_to_ref_pos, eval_marker, eval_home_switch, enable_only, use_ext_feedback,
    switch_at_drive, marker_after_fall, dir_negative};
  hod_top u_hod_top (.*);
  hod_motion_model u_hod_motion_model (.*);
  initial forever #10 clk_sys = ~clk_sys;
  task automatic test_done;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic hang;
    num_errors++;
    test_done;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // Edge passes first so strobes never toggle twice in one step
  task automatic bus(input logic w, input logic [1:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    repeat (50) begin
      @(posedge clk_sys);
      if (avs_waitrequest === 1'b0) break;
    end
    if (avs_waitrequest !== 1'b0) hang;
    got = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk("readdata", got, e);
  endtask
  task automatic go(input logic [15:0] w, input logic [1:0] c, input logic [10:0] e);
    bus(1'b1, 2'h0, {16'h0, w});
    bus(1'b1, 2'h1, {30'h0, c});
    @(posedge clk_sys);
    #1;
    chk("options", opts, e);
    // Unit homing leaves the last drive result standing
    chk("fb_valid", fb_valid, c[1]);
    if (c == 2'h1) begin
      repeat (200) begin
        if (homing_active === 1'b1) @(posedge clk_sys);
      end
      #1;
      if (homing_active !== 1'b0) hang;
      chk("fb_valid", fb_valid, 1'b1);
      chk("options", opts, 11'h0);
    end else begin
      bus(1'b1, 2'h0, 32'h0);
      rd(2'h0, {16'h0, w});
      bus(1'b1, 2'h1, 32'h4);
      @(posedge clk_sys);
      #1;
      chk("fb_valid", fb_valid, 1'b1);
      chk("options", opts, 11'h0);
    end
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(2'h0, 32'h0);
    rd(2'h3, 32'h0);
    bus(1'b1, 2'h0, 32'hffff);
    rd(2'h0, 32'h7ff);
    bus(1'b1, 2'h0, 32'h200);
    bus(1'b1, 2'h1, 32'h1);
    rd(2'h2, 32'h4);
    go(16'h05ff, 2'h1, 11'h5af);
    go(16'h0220, 2'h1, 11'h260);
    go(16'h0017, 2'h2, 11'h056);
    // High byte lane only
    avs_byteenable <= 4'h2;
    bus(1'b1, 2'h0, 32'hffff);
    avs_byteenable <= 4'h3;
    rd(2'h0, 32'h0717);
    // Both start bits: drive homing wins, then an abort
    bus(1'b1, 2'h0, 32'h0021);
    bus(1'b1, 2'h1, 32'h3);
    rd(2'h2, 32'h9);
    chk("options", opts, 11'h061);
    bus(1'b1, 2'h1, 32'h4);
    rd(2'h2, 32'h0);
    test_done;
  end
endmodule
`default_nettype wire
